// *** ilcc_capture_bank.v ***
// Read-only capture bank for link configuration received during lane alignment
`include "ilcc_defs.vh"

module ilcc_capture_bank #(
  parameter LANES = 4
) (
  // Clock and reset
  input  wire                 clock_in,
  input  wire                 rst_in,
  // Configuration octets from the lane deserialisers
  input  wire [LANES-1:0]     octet_valid_in,
  input  wire [LANES*4-1:0]   octet_index_in,
  input  wire [LANES*8-1:0]   octet_in,
  // Checksum method, mirrors the mode control bit
  input  wire                 sum_mode_in,
  // Register read port
  input  wire                 rd_en_in,
  input  wire [11:0]          rd_addr_in,
  output reg  [7:0]           rd_data_out,
  output reg                  rd_valid_out,
  // Status
  output reg  [LANES-1:0]     sum_match_out,
  output reg                  frame_size_ok_out,
  output reg                  ctrl_words_zero_out
);

  // ========================================================================
  // Per-lane capture
  // ========================================================================
  wire [LANES*5-1:0]  lane_id;
  wire [LANES*8-1:0]  rx_sum;
  wire [LANES*8-1:0]  cmp_sum;
  wire [LANES*64-1:0] lane_octets;
  wire [LANES-1:0]    lane_done;

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      ilcc_lane_capture u_lane (
        .clock_in       (clock_in),
        .rst_in         (rst_in),
        .octet_valid_in (octet_valid_in[g]),
        .octet_index_in (octet_index_in[g*4 +: 4]),
        .octet_in       (octet_in[g*8 +: 8]),
        .sum_mode_in    (sum_mode_in),
        .lane_id_out    (lane_id[g*5 +: 5]),
        .rx_sum_out     (rx_sum[g*8 +: 8]),
        .cmp_sum_out    (cmp_sum[g*8 +: 8]),
        .octets_out     (lane_octets[g*64 +: 64]),
        .done_out       (lane_done[g])
      );
    end
  endgenerate

  // ========================================================================
  // Lane 0 configuration octets (link-wide parameters come from lane 0)
  // ========================================================================
  wire [7:0] frame_octets_m1;
  wire [7:0] bits_sample_oct;
  wire [7:0] version_samples_oct;
  wire [7:0] density_ctrl_oct;
  wire [7:0] reserved_one_oct;

  assign frame_octets_m1     = lane_octets[7:0];
  assign bits_sample_oct     = lane_octets[39:32];
  assign version_samples_oct = lane_octets[47:40];
  assign density_ctrl_oct    = lane_octets[55:48];
  assign reserved_one_oct    = lane_octets[63:56];

  // Reserved octet two sits past the 64-bit window; kept locally
  reg [7:0] reserved_two_ff;

  // Lane 0 field views, each as the register presents it
  wire [4:0] received_bits_per_sample;
  wire [2:0] received_standard_version;
  wire [4:0] received_samples_per_frame;
  wire       received_high_density_flag;
  wire [4:0] received_ctrl_words_per_frame;

  assign received_bits_per_sample      = bits_sample_oct[`ILCC_SAMPLE_FIELD_MSB:0];
  assign received_standard_version     =
    version_samples_oct[`ILCC_VERSION_FIELD_MSB:`ILCC_VERSION_FIELD_LSB];
  assign received_samples_per_frame    = version_samples_oct[`ILCC_SAMPLE_FIELD_MSB:0];
  assign received_high_density_flag    = density_ctrl_oct[`ILCC_DENSITY_BIT];
  assign received_ctrl_words_per_frame = density_ctrl_oct[`ILCC_SAMPLE_FIELD_MSB:0];

  // ========================================================================
  // Reserved octet two capture for lane 0
  // ========================================================================
  // Kept here rather than widening every lane's octet bundle
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      reserved_two_ff <= `ILCC_RESET_VALUE;
    end else if (octet_valid_in[0] &&
                 (octet_index_in[3:0] == `ILCC_OCT_RESERVED_TWO)) begin
      reserved_two_ff <= octet_in[7:0];
    end
  end

  // ========================================================================
  // Helpers
  // ========================================================================
  // Lane identifier register image, upper bits forced to zero
  function [7:0] ilcc_id_image;
    input [4:0] id;
    begin
      ilcc_id_image = {3'h0, id};
    end
  endfunction

  // Legal stored frame sizes are 1, 2 or 4 octets
  function ilcc_frame_legal;
    input [7:0] f_m1;
    begin
      ilcc_frame_legal = (f_m1 == `ILCC_FRAME_ONE_OCTET) ||
                         (f_m1 == `ILCC_FRAME_TWO_OCTETS) ||
                         (f_m1 == `ILCC_FRAME_FOUR_OCTETS);
    end
  endfunction

  // Selects one byte of a packed lane vector
  function [7:0] ilcc_lane_byte;
    input [LANES*8-1:0] vec;
    input integer       lane;
    begin
      ilcc_lane_byte = vec[lane*8 +: 8];
    end
  endfunction

  // ========================================================================
  // Read decode
  // ========================================================================
  // Unmapped offsets read zero; no read has a side effect
  reg [7:0] nxt_rd_data;

  always @* begin
    nxt_rd_data = 8'h00;
    case (rd_addr_in)
      `ILCC_OFS_OCTETS_PER_FRAME:
        nxt_rd_data = frame_octets_m1;
      `ILCC_OFS_BITS_PER_SAMPLE:
        nxt_rd_data = {bits_sample_oct[7:5], received_bits_per_sample};
      `ILCC_OFS_VERSION_SAMPLES:
        nxt_rd_data = {received_standard_version,
                       received_samples_per_frame};
      `ILCC_OFS_DENSITY_CTRLWORDS:
        nxt_rd_data = {received_high_density_flag, 2'h0,
                       received_ctrl_words_per_frame};
      `ILCC_OFS_RESERVED_ONE:
        nxt_rd_data = reserved_one_oct;
      `ILCC_OFS_RESERVED_TWO:
        nxt_rd_data = reserved_two_ff;
      `ILCC_OFS_LANE0_RX_SUM:
        nxt_rd_data = ilcc_lane_byte(rx_sum, 0);
      `ILCC_OFS_LANE0_CMP_SUM:
        nxt_rd_data = ilcc_lane_byte(cmp_sum, 0);
      `ILCC_OFS_LANE1_ID:
        nxt_rd_data = ilcc_id_image(lane_id[9:5]);
      `ILCC_OFS_LANE1_RX_SUM:
        nxt_rd_data = ilcc_lane_byte(rx_sum, 1);
      `ILCC_OFS_LANE1_CMP_SUM:
        nxt_rd_data = ilcc_lane_byte(cmp_sum, 1);
      `ILCC_OFS_LANE2_ID:
        nxt_rd_data = ilcc_id_image(lane_id[14:10]);
      `ILCC_OFS_LANE2_RX_SUM:
        nxt_rd_data = ilcc_lane_byte(rx_sum, 2);
      `ILCC_OFS_LANE2_CMP_SUM:
        nxt_rd_data = ilcc_lane_byte(cmp_sum, 2);
      `ILCC_OFS_LANE3_ID:
        nxt_rd_data = ilcc_id_image(lane_id[19:15]);
      `ILCC_OFS_LANE3_RX_SUM:
        nxt_rd_data = ilcc_lane_byte(rx_sum, 3);
      `ILCC_OFS_LANE3_CMP_SUM:
        nxt_rd_data = ilcc_lane_byte(cmp_sum, 3);
      default:
        nxt_rd_data = 8'h00;
    endcase
  end

  // Registered read answer one cycle after the strobe
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out  <= 8'h00;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= rd_en_in;
      if (rd_en_in)
        rd_data_out <= nxt_rd_data;
    end
  end

  // ========================================================================
  // Status
  // ========================================================================
  // Match is judged only once a lane has closed a sequence; until then it
  // stays low so a stale zero-equals-zero never looks like a good link
  reg [LANES-1:0] nxt_match;
  integer         i;

  always @* begin
    nxt_match = sum_match_out;
    for (i = 0; i < LANES; i = i + 1) begin
      if (lane_done[i])
        nxt_match[i] = (rx_sum[i*8 +: 8] == cmp_sum[i*8 +: 8]);
    end
  end

  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sum_match_out       <= {LANES{1'b0}};
      frame_size_ok_out   <= 1'b0;
      ctrl_words_zero_out <= 1'b0;
    end else begin
      sum_match_out       <= nxt_match;
      frame_size_ok_out   <= ilcc_frame_legal(frame_octets_m1);
      ctrl_words_zero_out <= (received_ctrl_words_per_frame == 5'h00);
    end
  end

endmodule // ilcc_capture_bank

// *** ilcc_capture_bank_test.sv ***
// Self-checking bench for the configuration capture bank
module ilcc_capture_bank_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic        clock_in   = 1'b0;
  logic        rst_in     = 1'b1;
  logic        rd_en_in   = 1'b0;
  logic [11:0] rd_addr_in = 12'h000;
  wire  [3:0]  octet_valid_in;
  wire  [15:0] octet_index_in;
  wire  [31:0] octet_in;
  wire         sum_mode_in;
  wire  [7:0]  rd_data_out;
  wire         rd_valid_out;
  wire  [3:0]  sum_match_out;
  wire         frame_size_ok_out;
  wire         ctrl_words_zero_out;
  int          n_errors = 0;
  int          checked  = 0;
  int          cycles   = 0;
  logic [7:0]  c [13];
  logic [7:0]  s;
  logic [11:0] regs [19] = '{12'h404, 12'h408, 12'h409, 12'h40a, 12'h40b, 12'h40c, 12'h40d,
    12'h40e, 12'h412, 12'h415, 12'h416, 12'h41a, 12'h41d, 12'h41e, 12'h422, 12'h425,
    12'h426, 12'h40f, 12'h413};

  ilcc_capture_bank #(.LANES(4)) i_ilcc_capture_bank (
    .clock_in(clock_in), .rst_in(rst_in), .octet_valid_in(octet_valid_in),
    .octet_index_in(octet_index_in), .octet_in(octet_in), .sum_mode_in(sum_mode_in),
    .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .sum_match_out(sum_match_out),
    .frame_size_ok_out(frame_size_ok_out), .ctrl_words_zero_out(ctrl_words_zero_out));

  ilcc_tx_model i_ilcc_tx_model (
    .clock_in(clock_in), .octet_valid_out(octet_valid_in), .octet_index_out(octet_index_in),
    .octet_out(octet_in), .sum_mode_out(sum_mode_in));

  // 50 MHz clock
  always #10 clock_in = ~clock_in;

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One read: strobe for one cycle, answer sampled a cycle later
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    rd_en_in   <= 1'b1;
    rd_addr_in <= a;
    @(posedge clock_in);
    rd_en_in   <= 1'b0;
    rd_addr_in <= ~a;
    @(negedge clock_in);
    check({31'h0, rd_valid_out}, 32'h1);
    check({24'h0, rd_data_out}, {24'h0, exp});
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial begin
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    // Everything reads zero after reset, unmapped offsets too
    foreach (regs[i]) rd(regs[i], 8'h00);
    check({31'h0, frame_size_ok_out}, 32'h1);
    check({31'h0, ctrl_words_zero_out}, 32'h1);
    // Lane 0, octet checksum, revision B, high density
    c = '{8'h5a, 8'h03, 8'h00, 8'h03, 8'h01, 8'h1f, 8'h01, 8'h0f, 8'h0f, 8'h21, 8'h80,
          8'ha5, 8'h3c};
    i_ilcc_tx_model.send(0, c, 1'b1, 1'b0, 0);
    s = i_ilcc_tx_model.sum_of(c, 1'b1);
    rd(12'h404, 8'h01);
    rd(12'h408, 8'h0f);
    rd(12'h409, 8'h21);
    rd(12'h40a, 8'h80);
    rd(12'h40b, 8'ha5);
    rd(12'h40c, 8'h3c);
    rd(12'h40d, s);
    rd(12'h40e, s);
    check({31'h0, sum_match_out[0]}, 32'h1);
    // Field checksum, slow stream, bad checksum, invalid frame size
    c[4] = 8'h02;
    c[9] = 8'h23;
    c[10] = 8'h05;
    i_ilcc_tx_model.send(0, c, 1'b0, 1'b1, 1);
    s = i_ilcc_tx_model.sum_of(c, 1'b0);
    rd(12'h40a, 8'h05);
    rd(12'h40d, s + 8'h01);
    rd(12'h40e, s);
    check({31'h0, sum_match_out[0]}, 32'h0);
    check({31'h0, frame_size_ok_out}, 32'h0);
    check({31'h0, ctrl_words_zero_out}, 32'h0);
    // Original revision, four octets per frame, long gaps
    c[4] = 8'h03;
    c[9] = 8'h04;
    c[10] = 8'h00;
    i_ilcc_tx_model.send(0, c, 1'b1, 1'b0, 2);
    rd(12'h409, 8'h04);
    rd(12'h40e, i_ilcc_tx_model.sum_of(c, 1'b1));
    check({31'h0, frame_size_ok_out}, 32'h1);
    // Lanes 1 to 3, mixed methods, lane 3 with a bad checksum
    for (int ln = 1; ln < 4; ln++) begin
      c[2] = (ln == 1) ? 8'he1 : 8'(ln);
      i_ilcc_tx_model.send(ln, c, ln != 2, ln == 3, 0);
      s = i_ilcc_tx_model.sum_of(c, ln != 2);
      rd(12'h40a + 12'(8 * ln), 8'(ln));
      rd(12'h40d + 12'(8 * ln), s + {7'h0, ln == 3});
      rd(12'h40e + 12'(8 * ln), s);
      check({31'h0, sum_match_out[ln]}, {31'h0, ln != 3});
    end
    rd(12'h409, 8'h04);
    // Reset in mid-run clears the captures
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(12'h40d, 8'h00);
    rd(12'h416, 8'h00);
    check({28'h0, sum_match_out}, 32'h0);
    wrap_up();
  end
endmodule // ilcc_capture_bank_test

// *** ilcc_capture_checker.sv ***
// Port assertions for the configuration capture bank
module ilcc_capture_checker #(
  parameter LANES = 4
) (
  // Clock and reset
  input wire               clock_in,
  input wire               rst_in,
  // Octet stream
  input wire [LANES-1:0]   octet_valid_in,
  input wire [LANES*4-1:0] octet_index_in,
  input wire [LANES*8-1:0] octet_in,
  input wire               sum_mode_in,
  // Read port
  input wire               rd_en_in,
  input wire [11:0]        rd_addr_in,
  input wire [7:0]         rd_data_out,
  input wire               rd_valid_out,
  // Status
  input wire [LANES-1:0]   sum_match_out,
  input wire               frame_size_ok_out,
  input wire               ctrl_words_zero_out
);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Lanes taking their checksum octet this cycle
  wire [LANES-1:0] took_sum;
  genvar n;
  for (n = 0; n < LANES; n = n + 1) begin : g_took
    assign took_sum[n] = octet_valid_in[n] && (octet_index_in[4*n +: 4] == 4'hd);
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // Assertions
  // ==========================================================================
  read_answer_a: assert property (rd_en_in |=> rd_valid_out)
    else $error("read not answered");
  read_quiet_a: assert property (!rd_en_in |=> !rd_valid_out)
    else $error("read valid without request");
  read_hold_a: assert property (!rd_en_in |=> $stable(rd_data_out))
    else $error("read data changed without read");
  frame_ok_a: assert property (rd_en_in && rd_addr_in == 12'h404 |=>
    frame_size_ok_out == (rd_data_out inside {8'h00, 8'h01, 8'h03}))
    else $error("frame size flag disagrees with stored value");
  ctrl_zero_a: assert property (rd_en_in && rd_addr_in == 12'h40a |=>
    ctrl_words_zero_out == (rd_data_out[4:0] == 5'h00))
    else $error("control word flag disagrees with stored value");
  density_gap_a: assert property (rd_en_in && rd_addr_in == 12'h40a |=>
    rd_data_out[6:5] == 2'h0)
    else $error("reserved density bits not zero");
  lane_id_top_a: assert property (rd_en_in &&
    rd_addr_in inside {12'h412, 12'h41a, 12'h422} |=> rd_data_out[7:5] == 3'h0)
    else $error("lane identifier upper bits not zero");
  unmapped_zero_a: assert property (rd_en_in &&
    rd_addr_in inside {12'h40f, 12'h413} |=> rd_data_out == 8'h00)
    else $error("unmapped offset not zero");
  match_update_a: assert property (1'b1 |=>
    ((sum_match_out ^ $past(sum_match_out)) & ~$past(took_sum, 2)) == '0)
    else $error("match flag moved without checksum octet");
endmodule // ilcc_capture_checker

bind ilcc_capture_bank ilcc_capture_checker #(.LANES(LANES)) i_ilcc_capture_checker (
  .clock_in(clock_in), .rst_in(rst_in), .octet_valid_in(octet_valid_in),
  .octet_index_in(octet_index_in), .octet_in(octet_in), .sum_mode_in(sum_mode_in),
  .rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .sum_match_out(sum_match_out),
  .frame_size_ok_out(frame_size_ok_out), .ctrl_words_zero_out(ctrl_words_zero_out));

// *** ilcc_defs.vh ***
// Constants for the lane alignment configuration capture bank
`ifndef ILCC_DEFS_VH
`define ILCC_DEFS_VH

// ==========================================================================
// Register offsets
// ==========================================================================
`define ILCC_OFS_OCTETS_PER_FRAME   12'h404
`define ILCC_OFS_BITS_PER_SAMPLE    12'h408
`define ILCC_OFS_VERSION_SAMPLES    12'h409
`define ILCC_OFS_DENSITY_CTRLWORDS  12'h40a
`define ILCC_OFS_RESERVED_ONE       12'h40b
`define ILCC_OFS_RESERVED_TWO       12'h40c
`define ILCC_OFS_LANE0_RX_SUM       12'h40d
`define ILCC_OFS_LANE0_CMP_SUM      12'h40e
`define ILCC_OFS_LANE1_ID           12'h412
`define ILCC_OFS_LANE1_RX_SUM       12'h415
`define ILCC_OFS_LANE1_CMP_SUM      12'h416
`define ILCC_OFS_LANE2_ID           12'h41a
`define ILCC_OFS_LANE2_RX_SUM       12'h41d
`define ILCC_OFS_LANE2_CMP_SUM      12'h41e
`define ILCC_OFS_LANE3_ID           12'h422
`define ILCC_OFS_LANE3_RX_SUM       12'h425
`define ILCC_OFS_LANE3_CMP_SUM      12'h426

// ==========================================================================
// Field positions
// ==========================================================================
`define ILCC_SAMPLE_FIELD_MSB       4
`define ILCC_VERSION_FIELD_LSB      5
`define ILCC_VERSION_FIELD_MSB      7
`define ILCC_DENSITY_BIT            7
`define ILCC_LANE_ID_MSB            4

// ==========================================================================
// Version codes and reset value
// ==========================================================================
`define ILCC_VERSION_ORIGINAL       3'h0
`define ILCC_VERSION_REV_B          3'h1
`define ILCC_RESET_VALUE            8'h00

// ==========================================================================
// Configuration octet positions within the sequence
// ==========================================================================
`define ILCC_OCT_DEVICE_ID          4'h0
`define ILCC_OCT_BANK_ID            4'h1
`define ILCC_OCT_LANE_ID            4'h2
`define ILCC_OCT_LANES              4'h3
`define ILCC_OCT_FRAME_OCTETS       4'h4
`define ILCC_OCT_FRAMES_MULTI       4'h5
`define ILCC_OCT_CONVERTERS         4'h6
`define ILCC_OCT_RESOLUTION         4'h7
`define ILCC_OCT_BITS_SAMPLE        4'h8
`define ILCC_OCT_VERSION_SAMPLES    4'h9
`define ILCC_OCT_DENSITY_CTRL       4'ha
`define ILCC_OCT_RESERVED_ONE       4'hb
`define ILCC_OCT_RESERVED_TWO       4'hc
`define ILCC_OCT_CHECKSUM           4'hd

// ==========================================================================
// Checksum mode and valid frame sizes (stored minus one)
// ==========================================================================
`define ILCC_SUM_MODE_FIELDS        1'b0
`define ILCC_SUM_MODE_OCTETS        1'b1
`define ILCC_FRAME_ONE_OCTET        8'h00
`define ILCC_FRAME_TWO_OCTETS       8'h01
`define ILCC_FRAME_FOUR_OCTETS      8'h03

`endif

// *** ilcc_lane_capture.v ***
// One lane's capture of configuration octets, lane identifier and checksums
`include "ilcc_defs.vh"

module ilcc_lane_capture (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // Received configuration octet stream
  input  wire        octet_valid_in,
  input  wire [3:0]  octet_index_in,
  input  wire [7:0]  octet_in,
  // Checksum method select
  input  wire        sum_mode_in,
  // Captured values
  output reg  [4:0]  lane_id_out,
  output reg  [7:0]  rx_sum_out,
  output reg  [7:0]  cmp_sum_out,
  output reg  [63:0] octets_out,
  output reg         done_out
);

  reg [7:0] field_acc_ff;
  reg [7:0] octet_acc_ff;
  reg [7:0] nxt_field_acc;
  reg [7:0] nxt_octet_acc;

  // ========================================================================
  // Field-wise contribution of one configuration octet
  // ========================================================================
  function [7:0] ilcc_field_sum;
    input [3:0] idx;
    input [7:0] o;
    begin
      case (idx)
        `ILCC_OCT_BANK_ID:
          ilcc_field_sum = {4'h0, o[7:4]} + {4'h0, o[3:0]};
        `ILCC_OCT_LANE_ID:
          ilcc_field_sum = {7'h00, o[6]} + {7'h00, o[5]} + {3'h0, o[4:0]};
        `ILCC_OCT_LANES, `ILCC_OCT_DENSITY_CTRL:
          ilcc_field_sum = {7'h00, o[7]} + {3'h0, o[4:0]};
        `ILCC_OCT_FRAMES_MULTI:
          ilcc_field_sum = {3'h0, o[4:0]};
        `ILCC_OCT_RESOLUTION:
          ilcc_field_sum = {6'h00, o[7:6]} + {3'h0, o[4:0]};
        `ILCC_OCT_BITS_SAMPLE, `ILCC_OCT_VERSION_SAMPLES:
          ilcc_field_sum = {5'h00, o[7:5]} + {3'h0, o[4:0]};
        `ILCC_OCT_DEVICE_ID, `ILCC_OCT_FRAME_OCTETS, `ILCC_OCT_CONVERTERS,
        `ILCC_OCT_RESERVED_ONE, `ILCC_OCT_RESERVED_TWO:
          ilcc_field_sum = o;
        default:
          ilcc_field_sum = 8'h00;
      endcase
    end
  endfunction

  // Running sums restart on the first octet so a repeated sequence is clean
  always @* begin
    nxt_field_acc = field_acc_ff;
    nxt_octet_acc = octet_acc_ff;
    if (octet_valid_in && (octet_index_in < `ILCC_OCT_CHECKSUM)) begin
      if (octet_index_in == `ILCC_OCT_DEVICE_ID) begin
        nxt_field_acc = ilcc_field_sum(octet_index_in, octet_in);
        nxt_octet_acc = octet_in;
      end else begin
        nxt_field_acc = field_acc_ff + ilcc_field_sum(octet_index_in, octet_in);
        nxt_octet_acc = octet_acc_ff + octet_in;
      end
    end
  end

  // Capture as octets arrive; checksum octet closes the sequence
  always @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      field_acc_ff <= `ILCC_RESET_VALUE;
      octet_acc_ff <= `ILCC_RESET_VALUE;
      lane_id_out  <= 5'h00;
      rx_sum_out   <= `ILCC_RESET_VALUE;
      cmp_sum_out  <= `ILCC_RESET_VALUE;
      octets_out   <= 64'h0;
      done_out     <= 1'b0;
    end else begin
      field_acc_ff <= nxt_field_acc;
      octet_acc_ff <= nxt_octet_acc;
      done_out     <= 1'b0;
      if (octet_valid_in) begin
        if (octet_index_in == `ILCC_OCT_LANE_ID)
          lane_id_out <= octet_in[`ILCC_LANE_ID_MSB:0];
        // Octet 12 would fall past the bundle; the bank keeps it itself
        if ((octet_index_in >= `ILCC_OCT_FRAME_OCTETS) &&
            (octet_index_in <= `ILCC_OCT_RESERVED_ONE))
          octets_out[(octet_index_in - `ILCC_OCT_FRAME_OCTETS) * 8 +: 8] <= octet_in;
        if (octet_index_in == `ILCC_OCT_CHECKSUM) begin
          rx_sum_out  <= octet_in;
          // Method picked at sequence end, both sums kept running
          cmp_sum_out <= (sum_mode_in == `ILCC_SUM_MODE_OCTETS) ?
                         octet_acc_ff : field_acc_ff;
          done_out    <= 1'b1;
        end
      end
    end
  end

endmodule // ilcc_lane_capture

// *** ilcc_tx_model.sv ***
// Transmitter model that sends lane alignment configuration octets
module ilcc_tx_model (
  // Clock
  input  wire logic   clock_in,
  // Octet stream and checksum method towards the capture bank
  output logic [3:0]  octet_valid_out,
  output logic [15:0] octet_index_out,
  output logic [31:0] octet_out,
  output logic        sum_mode_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle lines
  // ==========================================================================
  // Idle lines show a refused index and zero data before any send, inverted data after one, never stale values
  initial begin
    octet_valid_out = 4'h0;
    octet_index_out = 16'hffff;
    octet_out       = 32'h0;
    sum_mode_out    = 1'b0;
  end

  task automatic idle(input int lane, input logic [7:0] v);
    octet_valid_out[lane]        <= 1'b0;
    octet_index_out[4*lane +: 4] <= 4'hf;
    octet_out[8*lane +: 8]       <= ~v;
  endtask

  // ==========================================================================
  // Checksum and sequence
  // ==========================================================================
  // Octet sum, or sum of the individual link fields
  function automatic logic [7:0] sum_of(input logic [7:0] c [13], input logic mode);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 13; k++) begin
      s += c[k];
    end
    if (!mode) begin
      s = c[0] + c[1][3:0] + c[1][7:4] + c[2][4:0] + c[2][5] + c[2][6] + c[3][4:0]
        + c[3][7] + c[4] + c[5][4:0] + c[6] + c[7][4:0] + c[7][7:6] + c[8][4:0]
        + c[8][7:5] + c[9][4:0] + c[9][7:5] + c[10][4:0] + c[10][7] + c[11] + c[12];
    end
    return s;
  endfunction

  // Octets 0..13 in order; corrupt spoils the checksum on purpose
  task automatic send(input int lane, input logic [7:0] c [13], input logic mode,
                      input logic corrupt, input int gap);
    logic [7:0] v;
    for (int k = 0; k < 14; k++) begin
      v = (k == 13) ? sum_of(c, mode) + {7'h0, corrupt} : c[k];
      @(posedge clock_in);
      sum_mode_out                 <= mode;
      octet_valid_out[lane]        <= 1'b1;
      octet_index_out[4*lane +: 4] <= k[3:0];
      octet_out[8*lane +: 8]       <= v;
      repeat (gap) begin
        @(posedge clock_in);
        idle(lane, v);
      end
    end
    @(posedge clock_in);
    idle(lane, v);
  endtask
endmodule // ilcc_tx_model
